// ===== common/iwu_consts.vh
// constants for the interrupt and watchdog unit
`ifndef IWU_CONSTS_VH
`define IWU_CONSTS_VH

// program address width and vectors
`define IWU_ADDR_W        10
`define IWU_VEC_TRAP      10'h001
`define IWU_VEC_HW        10'h008

// event flag / mask bit positions
`define IWU_BIT_TMR0      0
`define IWU_BIT_PBCHG     1
`define IWU_BIT_EXT       2
`define IWU_BIT_TMR1      3
`define IWU_BIT_WDT       6

// reset values
`define IWU_FLAG_RST      8'h00
`define IWU_MASK_RST      8'h00
`define IWU_GIE_RST       1'b0
`define IWU_TO_N_RST      1'b1

// timer wrap points
`define IWU_CNT_MAX       8'hff
`define IWU_CNT_MIN       8'h00

// watchdog base periods in microseconds
`define IWU_WDT_T0_US     3500
`define IWU_WDT_T1_US     15000
`define IWU_WDT_T2_US     60000
`define IWU_WDT_T3_US     250000

// watchdog oscillator tick period in nanoseconds
`define IWU_WDT_OSC_NS    1000

// base periods in oscillator ticks, all four times divide exactly
`define IWU_WDT_CNT0      ((`IWU_WDT_T0_US * 1000) / `IWU_WDT_OSC_NS)
`define IWU_WDT_CNT1      ((`IWU_WDT_T1_US * 1000) / `IWU_WDT_OSC_NS)
`define IWU_WDT_CNT2      ((`IWU_WDT_T2_US * 1000) / `IWU_WDT_OSC_NS)
`define IWU_WDT_CNT3      ((`IWU_WDT_T3_US * 1000) / `IWU_WDT_OSC_NS)

// watchdog counter width
`define IWU_WDT_W         20

`endif

// ===== src/iwu_wdt.v
// watchdog counter with the shared prescaler and time-out status bit
`timescale 1ns/100ps
`include "iwu_consts.vh"
module iwu_wdt #(
  parameter CNT0 = `IWU_WDT_CNT0,
  parameter CNT1 = `IWU_WDT_CNT1,
  parameter CNT2 = `IWU_WDT_CNT2,
  parameter CNT3 = `IWU_WDT_CNT3
) (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // configuration and control
  input  wire       cfg_enable_i,
  input  wire       cfg_irq_mode_i,
  input  wire [1:0] cfg_period_i,
  input  wire       run_i,
  input  wire       psc_assign_i,
  input  wire [2:0] psc_ratio_i,
  input  wire       osc_tick_i,
  input  wire       clear_i,
  // results
  output wire       expire_o,
  output wire       timeout_status_n_o
);

  reg [`IWU_WDT_W-1:0] cnt_ff;
  reg [`IWU_WDT_W-1:0] nxt_cnt;
  reg [7:0]            psc_ff;
  reg [7:0]            nxt_psc;
  reg                  to_n_ff;
  reg                  nxt_to_n;
  reg [`IWU_WDT_W-1:0] limit;
  reg [8:0]            psc_div;
  reg                  base_hit;
  reg                  expire;

  // base period chosen by the two-bit option
  always @* begin // RULE16
    case (cfg_period_i)
      2'h0:    limit = CNT0[`IWU_WDT_W-1:0] - 1'b1;
      2'h1:    limit = CNT1[`IWU_WDT_W-1:0] - 1'b1;
      2'h2:    limit = CNT2[`IWU_WDT_W-1:0] - 1'b1;
      default: limit = CNT3[`IWU_WDT_W-1:0] - 1'b1;
    endcase
  end

  always @* begin
    // reset mode 1:1..1:128, interrupt mode 1:2..1:256
    if (cfg_irq_mode_i) begin // RULE18
      psc_div = 9'h002 << psc_ratio_i;
    end else begin
      psc_div = 9'h001 << psc_ratio_i;
    end
    // counts oscillator ticks only while enabled and running
    base_hit = cfg_enable_i && run_i && osc_tick_i && (cnt_ff == limit); // RULE13 RULE14
    expire   = 1'b0;
    nxt_cnt  = cnt_ff;
    nxt_psc  = psc_ff;
    nxt_to_n = to_n_ff;
    if (cfg_enable_i && run_i && osc_tick_i) begin // RULE14
      if (base_hit) begin
        nxt_cnt = {`IWU_WDT_W{1'b0}};
        if (psc_assign_i) begin // RULE17
          if ({1'b0, psc_ff} == psc_div - 9'h001) begin
            nxt_psc = 8'h00;
            expire  = 1'b1;
          end else begin
            nxt_psc = psc_ff + 8'h01;
          end
        end else begin
          expire = 1'b1;
        end
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
    if (expire && !clear_i) begin
      nxt_to_n = 1'b0; // RULE15
    end
    if (clear_i) begin
      nxt_cnt = {`IWU_WDT_W{1'b0}};
      if (psc_assign_i) begin // RULE19
        nxt_psc  = 8'h00;
        nxt_to_n = 1'b1;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_ff  <= {`IWU_WDT_W{1'b0}};
      psc_ff  <= 8'h00;
      to_n_ff <= `IWU_TO_N_RST;
    end else begin
      cnt_ff  <= nxt_cnt;
      psc_ff  <= nxt_psc;
      to_n_ff <= nxt_to_n;
    end
  end

  // a clear in the same cycle wins over an expiry
  assign expire_o           = expire && !clear_i;
  assign timeout_status_n_o = to_n_ff;

endmodule // iwu_wdt

// ===== src/iwu_top.v
// interrupt controller with watchdog as interrupt and reset source
// How it works
// [RULE1] five hardware event sources are accepted
// [RULE2] unmask sets, mask clears global enable
// [RULE3] soft trap vectors to 0x001, clears enable
// [RULE4] return sets enable, core resumes saved point
// [RULE5] events set sticky flags, firmware zero clears
// [RULE6] flags read back only where mask set
// [RULE7] enabled pending flag vectors 0x008, clears enable
// [RULE8] nested firmware unmasks first, ends with return
// [RULE9] firmware avoids unmask right before return
// [RULE10] timer0 wrap sets its flag
// [RULE11] timer1 underflow sets its flag
// [RULE12] watchdog expiry in irq mode sets bit 6
// [RULE13] watchdog counts its own oscillator ticks
// [RULE14] run bit gates watchdog counting
// [RULE15] option picks reset or irq, clears status
// [RULE16] two-bit option picks base time-out
// [RULE17] prescaler assign lengthens watchdog time-out
// [RULE18] prescaler spans differ by watchdog mode
// [RULE19] clear instruction clears counter, prescaler, status (here prescaler and status only while the prescaler is assigned)
// [RULE20] port B input change sets change flag
// [RULE21] selected pin 0 edge sets external flag
// [RULE22] one vector for all, flags left set
// [RULE23] reset clears enable, flags and masks
`timescale 1ns/100ps
`include "iwu_consts.vh"
module iwu_top #(
  parameter WDT_CNT0 = `IWU_WDT_CNT0,
  parameter WDT_CNT1 = `IWU_WDT_CNT1,
  parameter WDT_CNT2 = `IWU_WDT_CNT2,
  parameter WDT_CNT3 = `IWU_WDT_CNT3
) (
  // clock and reset
  input  wire                  core_clk_i,
  input  wire                  rst_i,
  // executed instruction strobes from the core
  input  wire                  irq_unmask_instr_i,
  input  wire                  irq_mask_instr_i,
  input  wire                  soft_trap_instr_i,
  input  wire                  return_from_isr_i,
  input  wire                  watchdog_clear_instr_i,
  // fetch redirection to the core
  output wire                  vec_take_o,
  output wire [`IWU_ADDR_W-1:0] vec_addr_o,
  output wire                  isr_return_o,
  // timer event sources
  input  wire [7:0]            tmr0_count_i,
  input  wire [7:0]            tmr1_count_i,
  // port B event sources
  input  wire [7:0]            pb_pin_i,
  input  wire [7:0]            pb_is_input_i,
  input  wire [7:0]            pb_wake_en_i,
  input  wire                  ext_irq_en_i,
  input  wire                  ext_edge_fall_i,
  // flag and mask register access
  input  wire                  flag_wr_i,
  input  wire [7:0]            flag_wdata_i,
  output wire [7:0]            event_flag_reg_o,
  input  wire                  mask_wr_i,
  input  wire [7:0]            mask_wdata_i,
  output wire [7:0]            event_mask_reg_o,
  output wire                  global_irq_enable_o,
  // watchdog configuration and control
  input  wire                  cfg_wdt_enable_i,
  input  wire                  cfg_wdt_irq_mode_i,
  input  wire [1:0]            cfg_wdt_period_i,
  input  wire                  watchdog_run_i,
  input  wire                  prescaler_assign_i,
  input  wire [2:0]            prescaler_ratio_i,
  input  wire                  wdt_osc_tick_i,
  // watchdog results
  output wire                  wdt_reset_o,
  output wire                  timeout_status_n_o
);

  reg [7:0]             flag_ff;
  reg [7:0]             mask_ff;
  reg                   gie_ff;
  reg                   nxt_gie;
  reg [7:0]             tmr0_prev_ff;
  reg [7:0]             tmr1_prev_ff;
  reg [7:0]             pb_prev_ff;
  reg                   hist_valid_ff;
  reg                   vec_take_ff;
  reg                   nxt_vec_take;
  reg [`IWU_ADDR_W-1:0] vec_addr_ff;
  reg [`IWU_ADDR_W-1:0] nxt_vec_addr;
  reg                   ret_ff;
  reg                   wdt_reset_ff;
  reg [7:0]             flag_rd_ff;
  reg [7:0]             nxt_flag;
  reg [7:0]             ev_set;
  reg [7:0]             pb_change;
  reg                   ext_edge;
  reg                   tmr0_wrap;
  reg                   tmr1_wrap;
  reg [7:0]             pb_watch;
  reg                   nxt_ret;
  reg                   nxt_wdt_reset;
  wire                  wdt_expire;
  wire                  hw_pending;
  wire                  hw_take;

  // watchdog counter and prescaler
  iwu_wdt #(
    .CNT0 (WDT_CNT0),
    .CNT1 (WDT_CNT1),
    .CNT2 (WDT_CNT2),
    .CNT3 (WDT_CNT3)
  ) u_wdt (
    .core_clk_i         (core_clk_i),
    .rst_i              (rst_i),
    .cfg_enable_i       (cfg_wdt_enable_i),
    .cfg_irq_mode_i     (cfg_wdt_irq_mode_i),
    .cfg_period_i       (cfg_wdt_period_i),
    .run_i              (watchdog_run_i),
    .psc_assign_i       (prescaler_assign_i),
    .psc_ratio_i        (prescaler_ratio_i),
    .osc_tick_i         (wdt_osc_tick_i),
    .clear_i            (watchdog_clear_instr_i),
    .expire_o           (wdt_expire),
    .timeout_status_n_o (timeout_status_n_o)
  );

  // timer wrap detection against last cycle's count
  always @* begin
    tmr0_wrap = (tmr0_prev_ff == `IWU_CNT_MAX) &&
                (tmr0_count_i == `IWU_CNT_MIN); // RULE10
    tmr1_wrap = (tmr1_prev_ff == `IWU_CNT_MIN) &&
                (tmr1_count_i == `IWU_CNT_MAX); // RULE11
  end

  // pins watched for change, pin 0 is lost to the external edge while that is enabled
  always @* begin
    pb_watch = pb_is_input_i & pb_wake_en_i;
    if (ext_irq_en_i) begin
      pb_watch[0] = 1'b0; // RULE20
    end
  end

  // level change per port B pin
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp = gp + 1) begin : g_pin
      always @* begin
        if (pb_watch[gp]) begin // RULE20
          pb_change[gp] = pb_pin_i[gp] ^ pb_prev_ff[gp];
        end else begin
          pb_change[gp] = 1'b0;
        end
      end
    end
  endgenerate

  // external pin edge of the selected polarity
  always @* begin
    if (ext_edge_fall_i) begin // RULE21
      ext_edge = pb_prev_ff[0] && !pb_pin_i[0];
    end else begin
      ext_edge = !pb_prev_ff[0] && pb_pin_i[0];
    end
  end

  // event detection, the first cycle after reset has no history
  always @* begin
    ev_set = 8'h00;
    if (hist_valid_ff) begin // RULE1
      ev_set[`IWU_BIT_TMR0]  = tmr0_wrap; // RULE10
      ev_set[`IWU_BIT_TMR1]  = tmr1_wrap; // RULE11
      ev_set[`IWU_BIT_PBCHG] = |pb_change; // RULE20
      ev_set[`IWU_BIT_EXT]   = ext_irq_en_i && ext_edge; // RULE21
    end
    ev_set[`IWU_BIT_WDT] = wdt_expire && cfg_wdt_irq_mode_i; // RULE12
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      tmr0_prev_ff  <= 8'h00;
      tmr1_prev_ff  <= 8'h00;
      pb_prev_ff    <= 8'h00;
      hist_valid_ff <= 1'b0;
    end else begin
      tmr0_prev_ff  <= tmr0_count_i;
      tmr1_prev_ff  <= tmr1_count_i;
      pb_prev_ff    <= pb_pin_i;
      hist_valid_ff <= 1'b1;
    end
  end

  // sticky flags: firmware writes 0 to clear, a new event wins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      always @* begin
        if (ev_set[gi]) begin // RULE5
          nxt_flag[gi] = 1'b1;
        end else if (flag_wr_i && !flag_wdata_i[gi]) begin
          nxt_flag[gi] = 1'b0;
        end else begin
          nxt_flag[gi] = flag_ff[gi];
        end
      end
    end
  endgenerate

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_ff <= `IWU_FLAG_RST; // RULE23
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // mask loads whole on a write
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_ff <= `IWU_MASK_RST; // RULE23
    end else if (mask_wr_i) begin
      mask_ff <= mask_wdata_i;
    end
  end

  // any enabled flag raises one request, flags are left alone
  assign hw_pending = |(flag_ff & mask_ff); // RULE22
  assign hw_take    = hw_pending && gie_ff && !soft_trap_instr_i; // RULE7

  // fetch redirection: trap first, then an enabled hardware request
  always @* begin
    nxt_vec_take = 1'b0;
    nxt_vec_addr = vec_addr_ff;
    if (soft_trap_instr_i) begin // RULE3
      nxt_vec_take = 1'b1;
      nxt_vec_addr = `IWU_VEC_TRAP;
    end else if (hw_take) begin // RULE7
      nxt_vec_take = 1'b1;
      nxt_vec_addr = `IWU_VEC_HW;
    end
  end

  // global enable: a vector clears it ahead of any instruction
  always @* begin
    if (nxt_vec_take) begin // RULE3 RULE7
      nxt_gie = 1'b0;
    end else if (irq_unmask_instr_i || return_from_isr_i) begin // RULE2 RULE4
      nxt_gie = 1'b1;
    end else if (irq_mask_instr_i) begin // RULE2
      nxt_gie = 1'b0;
    end else begin
      nxt_gie = gie_ff;
    end
  end

  // return and watchdog reset pulses, decided one cycle ahead
  always @* begin
    nxt_ret       = return_from_isr_i && !soft_trap_instr_i; // RULE4
    nxt_wdt_reset = wdt_expire && !cfg_wdt_irq_mode_i; // RULE15
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      gie_ff <= `IWU_GIE_RST; // RULE23
    end else begin
      gie_ff <= nxt_gie;
    end
  end

  // vector pulse and the address it points at
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      vec_take_ff <= 1'b0;
      vec_addr_ff <= {`IWU_ADDR_W{1'b0}};
    end else begin
      vec_take_ff <= nxt_vec_take;
      vec_addr_ff <= nxt_vec_addr;
    end
  end

  // core pops its saved return point on this pulse
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ret_ff <= 1'b0;
    end else begin
      ret_ff <= nxt_ret; // RULE4
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      wdt_reset_ff <= 1'b0;
    end else begin
      wdt_reset_ff <= nxt_wdt_reset; // RULE15
    end
  end

  // readback masked with the mask as it stood before this edge
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_rd_ff <= 8'h00;
    end else begin
      flag_rd_ff <= nxt_flag & mask_ff; // RULE6
    end
  end

  assign vec_take_o          = vec_take_ff;
  assign vec_addr_o          = vec_addr_ff;
  assign isr_return_o        = ret_ff;
  assign event_flag_reg_o    = flag_rd_ff;
  assign event_mask_reg_o    = mask_ff;
  assign global_irq_enable_o = gie_ff;
  assign wdt_reset_o         = wdt_reset_ff;

endmodule // iwu_top

// ===== dv/iwu_checker_asserts.sv
// concurrent checks on the interrupt and watchdog unit ports
`timescale 1ns/100ps
`include "iwu_consts.vh"
module iwu_checker (
  // clock and reset
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  // stimulus seen by the unit
  input wire logic                   irq_unmask_instr_i,
  input wire logic                   irq_mask_instr_i,
  input wire logic                   soft_trap_instr_i,
  input wire logic                   return_from_isr_i,
  input wire logic                   flag_wr_i,
  input wire logic                   mask_wr_i,
  input wire logic [7:0]             tmr0_count_i,
  // results
  input wire logic                   vec_take_o,
  input wire logic [`IWU_ADDR_W-1:0] vec_addr_o,
  input wire logic                   isr_return_o,
  input wire logic [7:0]             event_flag_reg_o,
  input wire logic [7:0]             event_mask_reg_o,
  input wire logic                   global_irq_enable_o,
  input wire logic                   wdt_reset_o,
  input wire logic                   timeout_status_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_trap;
    soft_trap_instr_i |=> vec_take_o && vec_addr_o == `IWU_VEC_TRAP && !global_irq_enable_o;
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector wrong");
  property p_mask;
    irq_mask_instr_i && !irq_unmask_instr_i && !return_from_isr_i |=> !global_irq_enable_o;
  endproperty
  a_mask: assert property (p_mask) else $error("mask left enable set");
  property p_unmask;
    irq_unmask_instr_i && !soft_trap_instr_i && !global_irq_enable_o
      |=> global_irq_enable_o && !vec_take_o;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask failed");
  property p_ret;
    return_from_isr_i && !soft_trap_instr_i && !global_irq_enable_o
      |=> isr_return_o && global_irq_enable_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return failed");
  property p_hw;
    global_irq_enable_o && (|event_flag_reg_o) && !soft_trap_instr_i && !$past(flag_wr_i)
      && !$past(mask_wr_i) |=> vec_take_o && vec_addr_o == `IWU_VEC_HW && !global_irq_enable_o;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware vector missing");
  property p_nohw;
    !global_irq_enable_o && !soft_trap_instr_i |=> !vec_take_o;
  endproperty
  a_nohw: assert property (p_nohw) else $error("vector while disabled");
  property p_sticky;
    !flag_wr_i && !$past(mask_wr_i)
      |=> (event_flag_reg_o & $past(event_flag_reg_o)) == $past(event_flag_reg_o);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_masked;
    !$past(mask_wr_i) |-> (event_flag_reg_o & ~event_mask_reg_o) == 8'h00;
  endproperty
  a_masked: assert property (p_masked) else $error("unmasked flag visible");
  property p_t0;
    $past(tmr0_count_i) == 8'hff && tmr0_count_i == 8'h00 && event_mask_reg_o[0]
      && !flag_wr_i |-> ##[1:2] event_flag_reg_o[0];
  endproperty
  a_t0: assert property (p_t0) else $error("timer0 flag missing");
  property p_wdt;
    wdt_reset_o |-> !timeout_status_n_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("status not cleared");
  property p_rst;
    $fell(rst_i) |-> event_flag_reg_o == 8'h00 && event_mask_reg_o == 8'h00
      && !global_irq_enable_o && timeout_status_n_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule // iwu_checker

bind iwu_top iwu_checker u_chk (.*);

// ===== dv/iwu_core_model.sv
// core and firmware model: service routine clears flags then returns
`timescale 1ns/100ps
`include "iwu_consts.vh"
module iwu_core_model #(
  parameter int DLY = 3
) (
  input wire logic                   clk_i,
  input wire logic                   en_i,
  input wire logic                   take_i,
  input wire logic [`IWU_ADDR_W-1:0] addr_i,
  output logic                       clr_o,
  output logic                       ret_o
);
  int cnt;
  initial begin
    cnt = 0;
    clr_o = 1'b0;
    ret_o = 1'b0;
  end
  always @(negedge clk_i) begin
    if (en_i && take_i && addr_i == `IWU_VEC_HW) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
    clr_o <= (cnt == 2);
    ret_o <= (cnt == 1);
  end
endmodule // iwu_core_model

// ===== dv/interrupt_and_watchdog_unit_test.sv
// self-checking bench for the interrupt and watchdog unit
`timescale 1ns/100ps
`include "iwu_consts.vh"
module interrupt_and_watchdog_unit_test;
  logic core_clk_i = 0, rst_i = 1, eie = 0, efall = 0, fwr = 0, mwr = 0, fwe = 0;
  logic wen = 0, wirq = 0, run = 0, pa = 0, tick = 0;
  logic [4:0] ins = 0;
  logic [7:0] t0 = 8'h80, t1 = 8'h80, pin = 0, pbin = 0, wk = 0, fd = 0, md = 0;
  logic [1:0] per = 0;
  logic [2:0] ratio = 0;
  logic take, ret, global_irq_enable, wrst, ton, fclr, fret;
  logic [9:0] vaddr;
  logic [7:0] flg, msk;
  int fails = 0, total_checks = 0, ntake = 0, nrst = 0;
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    ntake <= ntake + take;
    nrst <= nrst + wrst;
  end
  iwu_top #(.WDT_CNT0(4), .WDT_CNT1(6), .WDT_CNT2(8), .WDT_CNT3(10)) dut (
    .core_clk_i, .rst_i, .irq_unmask_instr_i(ins[0]), .irq_mask_instr_i(ins[1]),
    .soft_trap_instr_i(ins[2]), .return_from_isr_i(ins[3] | fret),
    .watchdog_clear_instr_i(ins[4]), .vec_take_o(take), .vec_addr_o(vaddr),
    .isr_return_o(ret), .tmr0_count_i(t0), .tmr1_count_i(t1), .pb_pin_i(pin),
    .pb_is_input_i(pbin), .pb_wake_en_i(wk), .ext_irq_en_i(eie), .ext_edge_fall_i(efall),
    .flag_wr_i(fwr | fclr), .flag_wdata_i(fclr ? 8'h00 : fd), .event_flag_reg_o(flg),
    .mask_wr_i(mwr), .mask_wdata_i(md), .event_mask_reg_o(msk), .global_irq_enable_o(global_irq_enable),
    .cfg_wdt_enable_i(wen), .cfg_wdt_irq_mode_i(wirq), .cfg_wdt_period_i(per),
    .watchdog_run_i(run), .prescaler_assign_i(pa), .prescaler_ratio_i(ratio),
    .wdt_osc_tick_i(tick), .wdt_reset_o(wrst), .timeout_status_n_o(ton));
  iwu_core_model #(.DLY(3)) fw (.clk_i(core_clk_i), .en_i(fwe), .take_i(take),
    .addr_i(vaddr), .clr_o(fclr), .ret_o(fret));
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // one-cycle instruction strobe
  task op(input int i);
    ins[i] = 1'b1;
    cyc(1);
    ins[i] = 1'b0;
  endtask
  task wr(input logic f, input logic [7:0] d);
    fd = d;
    md = d;
    fwr = f;
    mwr = !f;
    cyc(1);
    fwr = 0;
    mwr = 0;
  endtask
  task tk(input int n);
    repeat (n) begin
      tick = 1;
      cyc(1);
      tick = 0;
      cyc(1);
    end
  endtask
  function int wn(input int p, input int d);
    return (4 + 2 * p) * d;
  endfunction
  // clear, run to one tick short, then expire
  task wrun(input int n, input logic f, input int rs);
    int n0;
    n0 = nrst;
    wr(1, 8'h00);
    op(4);
    tk(n - 1);
    chk({ton, flg[6]}, 2'b10, "wdt early");
    tk(1);
    chk({ton, flg[6]}, {1'b0, f}, "wdt expiry");
    chk(16'(nrst - n0), 16'(rs), "wdt reset");
  endtask
  initial begin
    #100000;
    fails++;
    close_out;
  end
  initial begin
    int m, r, p, n0;
    void'($urandom(20453));
    cyc(6);
    rst_i = 0;
    cyc(1);
    chk({flg, msk}, 16'h0000, "reset regs");
    chk({global_irq_enable, ton}, 2'b01, "reset bits");
    $display("test reset done");
    for (int g = 0; g < 2; g++) begin
      if (g) op(0);
      op(2);
      chk({take, vaddr, global_irq_enable}, {1'b1, `IWU_VEC_TRAP, 1'b0}, "trap");
    end
    op(0);
    chk(global_irq_enable, 1, "unmask");
    op(1);
    chk(global_irq_enable, 0, "mask");
    op(3);
    chk({ret, global_irq_enable}, 2'b11, "return");
    op(1);
    $display("test instructions done");
    m = $urandom;
    wr(0, m[7:0]);
    pbin = 8'hff;
    wk = 8'hff;
    t0 = 8'hff;
    t1 = 8'h00;
    cyc(1);
    t0 = 8'h00;
    t1 = 8'hff;
    pin[3] = 1;
    cyc(2);
    chk({flg, msk}, {8'h0b & m[7:0], m[7:0]}, "events masked");
    wr(0, 8'hff);
    cyc(1);
    chk(flg, 8'h0b, "events sticky");
    wr(1, 8'h00);
    eie = 1;
    for (int e = 0; e < 2; e++) begin
      efall = e[0];
      pin[0] = ~pin[0];
      cyc(2);
      chk(flg, 8'h04, "ext edge");
      wr(1, 8'h00);
    end
    pin[0] = ~pin[0];
    cyc(2);
    chk(flg, 8'h00, "wrong edge");
    $display("test events done");
    fwe = 1;
    t0 = 8'hff;
    t1 = 8'h00;
    cyc(1);
    t0 = 8'h00;
    t1 = 8'hff;
    cyc(2);
    n0 = ntake;
    op(0);
    cyc(1);
    chk({take, vaddr, global_irq_enable, flg}, {1'b1, `IWU_VEC_HW, 1'b0, 8'h09}, "hw vector");
    cyc(8);
    chk({global_irq_enable, flg}, 9'h100, "isr return");
    chk(16'(ntake - n0), 1, "one vector");
    op(1);
    fwe = 0;
    $display("test vector done");
    p = $urandom % 4;
    r = $urandom % 3;
    per = p[1:0];
    wen = 1;
    run = 1;
    wirq = 1;
    wrun(wn(p, 1), 1'b1, 0);
    op(4);
    chk(ton, 0, "clear keeps status");
    pa = 1;
    cyc(1);
    op(4);
    chk(ton, 1, "clear status");
    ratio = r[2:0];
    for (int q = 0; q < 4; q++) begin
      per = q[1:0];
      wrun(wn(q, 2 << r), 1'b1, 0);
    end
    wirq = 0;
    wrun(wn(3, 1 << r), 1'b0, 1);
    run = 0;
    n0 = nrst;
    op(4);
    tk(wn(3, 8));
    chk({ton, 15'(nrst - n0)}, 16'h8000, "run gate");
    run = 1;
    wen = 0;
    tk(wn(3, 8));
    chk({ton, 15'(nrst - n0)}, 16'h8000, "enable gate");
    $display("test watchdog done");
    close_out;
  end
endmodule // interrupt_and_watchdog_unit_test
